// ===== design/bre_exec.v
`timescale 1ns/10ps
`include "bre_map.vh"
module bre_exec (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire op_valid_i,
	input wire [2:0] op_sel_i,
	input wire [6:0] file_addr_i,
	input wire [2:0] bit_idx_i,
	input wire dest_file_i,
	input wire [7:0] imm_i,
	input wire push_i,
	input wire [12:0] push_pc_i,
	output wire op_ready_o,
	output reg [7:0] acc_o,
	output reg zero_flag_o,
	output reg [12:0] pc_o,
	output reg pc_load_o,
	output reg flush_o,
	output reg [7:0] interrupt_control_reg_o,
	output wire global_irq_enable_o,
	output reg [2:0] stack_ptr_o,
	output reg done_o
);
	// ----------------------------------------
	// States.
	// ----------------------------------------
	localparam ST_IDLE = 3'b001;
	localparam ST_READ = 3'b010;
	localparam ST_SECOND = 3'b100;

	reg [2:0] state_q;
	reg [2:0] op_q;
	reg [6:0] addr_q;
	reg [2:0] bit_q;
	reg dest_q;
	reg [7:0] imm_q;
	reg [12:0] stack_q [0:`BRE_STACK_DEPTH-1];
	wire [7:0] file_rd;
	reg wr_en;
	reg [7:0] wr_data;
	reg [7:0] and_res;
	integer i;
	wire push_ok;
	wire [12:0] stack_top_entry;

	function [7:0] bit_mask;
		input [2:0] idx;
		begin
			bit_mask = 8'h01 << idx;
		end
	endfunction

	function [2:0] sp_dec;
		input [2:0] sp;
		begin
			sp_dec = sp - 3'h1;
		end
	endfunction

	assign op_ready_o = (state_q == ST_IDLE);
	// A push is ignored while an operation is in flight.
	assign push_ok = push_i && (state_q == ST_IDLE);
	assign stack_top_entry = stack_q[sp_dec(stack_ptr_o)];
	assign global_irq_enable_o = interrupt_control_reg_o[`BRE_GIE_BIT];

	// ----------------------------------------
	// File memory.
	// ----------------------------------------
	// The operand is read at the take edge and stands in the next cycle.
	bre_file_mem u_mem (
		.ref_clk_i(ref_clk_i),
		.rd_addr_i(file_addr_i),
		.rd_data_o(file_rd),
		.wr_en_i(wr_en),
		.wr_addr_i(addr_q),
		.wr_data_i(wr_data)
	);

	// ----------------------------------------
	// Read-modify-write path.
	// ----------------------------------------
	always @* begin
		and_res = acc_o & file_rd;
		wr_en = 1'b0;
		wr_data = 8'h00;
		if (state_q == ST_READ) begin
			if (op_q == `BRE_OP_SET_BIT) begin
				wr_en = 1'b1;
				wr_data = file_rd | bit_mask(bit_q);
			end else if (op_q == `BRE_OP_AND_FILE && dest_q) begin
				wr_en = 1'b1;
				wr_data = and_res;
			end
		end
	end

	// ----------------------------------------
	// Return stack storage.
	// ----------------------------------------
	// The pointer names the next free slot and wraps at the depth.
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (i = 0; i < `BRE_STACK_DEPTH; i = i + 1) begin
				stack_q[i] <= 13'h0000;
			end
		end else if (push_ok) begin
			stack_q[stack_ptr_o] <= push_pc_i;
		end
	end

	// ----------------------------------------
	// Execution sequencer.
	// ----------------------------------------
	always @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= ST_IDLE;
			op_q <= `BRE_OP_NOP;
			addr_q <= 7'h00;
			bit_q <= 3'h0;
			dest_q <= 1'b0;
			imm_q <= 8'h00;
			acc_o <= `BRE_ACC_RST;
			zero_flag_o <= 1'b0;
			pc_o <= `BRE_PC_RST;
			pc_load_o <= 1'b0;
			flush_o <= 1'b0;
			interrupt_control_reg_o <= `BRE_INTERRUPT_CONTROL_REG_RST;
			stack_ptr_o <= 3'h0;
			done_o <= 1'b0;
		end else begin
			pc_load_o <= 1'b0;
			flush_o <= 1'b0;
			done_o <= 1'b0;
			if (push_ok) begin
				stack_ptr_o <= stack_ptr_o + 3'h1;
			end
			case (state_q)
			ST_IDLE: begin
				if (op_valid_i) begin
					op_q <= op_sel_i;
					addr_q <= file_addr_i;
					bit_q <= bit_idx_i;
					dest_q <= dest_file_i;
					imm_q <= imm_i;
					case (op_sel_i)
					`BRE_OP_AND_IMM: begin
						acc_o <= acc_o & imm_i;
						zero_flag_o <= ((acc_o & imm_i) == 8'h00);
						done_o <= 1'b1;
					end
					`BRE_OP_SET_BIT, `BRE_OP_AND_FILE,
					`BRE_OP_TEST_SKIP: begin
						state_q <= ST_READ;
					end
					`BRE_OP_IRQ_RET, `BRE_OP_RET_LIT,
					`BRE_OP_RETURN: begin
						pc_o <= stack_top_entry;
						stack_ptr_o <= sp_dec(stack_ptr_o);
						state_q <= ST_READ;
					end
					default: begin
						done_o <= 1'b1;
					end
					endcase
				end
			end
			ST_READ: begin
				state_q <= ST_IDLE;
				if (op_q == `BRE_OP_AND_FILE) begin
					zero_flag_o <= (and_res == 8'h00);
					if (!dest_q) begin
						acc_o <= and_res;
					end
					done_o <= 1'b1;
				end else if (op_q == `BRE_OP_TEST_SKIP) begin
					if (file_rd[bit_q]) begin
						done_o <= 1'b1;
					end else begin
						// The fetched instruction is dropped for a no-op.
						flush_o <= 1'b1;
						state_q <= ST_SECOND;
					end
				end else if (op_q == `BRE_OP_SET_BIT) begin
					done_o <= 1'b1;
				end else begin
					// Returns spend their second cycle here.
					state_q <= ST_SECOND;
				end
			end
			ST_SECOND: begin
				state_q <= ST_IDLE;
				done_o <= 1'b1;
				// Returns hand the popped address on here.
				if (op_q != `BRE_OP_TEST_SKIP) begin
					pc_load_o <= 1'b1;
				end
				if (op_q == `BRE_OP_IRQ_RET) begin
					interrupt_control_reg_o[`BRE_GIE_BIT] <= 1'b1;
				end
				if (op_q == `BRE_OP_RET_LIT) begin
					acc_o <= imm_q;
				end
			end
			default: begin
				state_q <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // bre_exec

// ===== design/bre_map.vh
`ifndef BRE_MAP_VH
`define BRE_MAP_VH
// Operation selects presented on op_sel_i.
`define BRE_OP_NOP 3'h0
`define BRE_OP_SET_BIT 3'h1
`define BRE_OP_AND_IMM 3'h2
`define BRE_OP_AND_FILE 3'h3
`define BRE_OP_TEST_SKIP 3'h4
`define BRE_OP_IRQ_RET 3'h5
`define BRE_OP_RET_LIT 3'h6
`define BRE_OP_RETURN 3'h7
// Field positions and widths.
`define BRE_GIE_BIT 7
`define BRE_FADDR_W 7
`define BRE_PC_W 13
`define BRE_STACK_DEPTH 8
`define BRE_SP_W 3
// Reset values.
`define BRE_ACC_RST 8'h00
`define BRE_PC_RST 13'h0000
`define BRE_INTERRUPT_CONTROL_REG_RST 8'h00
// Cycle counts.
`define BRE_ONE_CYCLE 1
`define BRE_TWO_CYCLE 2
`endif

// ===== design/bre_file_mem.v
`timescale 1ns/10ps
// ----------------------------------------
// File register memory, registered read.
// ----------------------------------------
module bre_file_mem (
	input wire ref_clk_i,
	input wire [6:0] rd_addr_i,
	output reg [7:0] rd_data_o,
	input wire wr_en_i,
	input wire [6:0] wr_addr_i,
	input wire [7:0] wr_data_i
);
	reg [7:0] mem [0:127];

	always @(posedge ref_clk_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem[rd_addr_i];
	end
endmodule // bre_file_mem

// ===== sim/bre_exec_props.sv
`timescale 1ns/10ps
module bre_exec_props (
	input wire ref_clk_i,
	input wire sys_rst_i,
	input wire op_valid_i,
	input wire [2:0] op_sel_i,
	input wire op_ready_o,
	input wire pc_load_o,
	input wire flush_o,
	input wire global_irq_enable_o,
	input wire [2:0] stack_ptr_o,
	input wire done_o
);
	// One-hot of the operation taken at this edge.
	wire [7:0] go = {7'h00, op_valid_i && op_ready_o} << op_sel_i;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	a_and_imm_done: assert property (go[2] |=> done_o)
		else $error("late");
	a_single_op: assert property (
		go[1] || go[3] |=> !done_o ##1 done_o) else $error("late");
	a_return_time: assert property (
		go[7:5] != 3'h0 |=> (!done_o && !op_ready_o)[*2]
		##1 (done_o && pc_load_o && op_ready_o))
		else $error("late");
	a_irq_enable: assert property (
		go[5] |-> ##3 global_irq_enable_o) else $error("no enable");
	a_stack_pop: assert property (
		go[7:5] != 3'h0 |=> stack_ptr_o == $past(stack_ptr_o) - 3'h1)
		else $error("no pop");
	a_skip_done: assert property (flush_o |=> done_o)
		else $error("late");
	a_test_time: assert property (
		go[4] |=> !done_o ##1 (done_o ^ flush_o)) else $error("bad");
	a_busy_held: assert property (go[7:3] != 5'h00 |=> !op_ready_o)
		else $error("ready");
	cover property (flush_o);
	cover property (pc_load_o && global_irq_enable_o);
	cover property (go[3]);
endmodule // bre_exec_props
bind bre_exec bre_exec_props u_bre_exec_props (
	.ref_clk_i(ref_clk_i),
	.sys_rst_i(sys_rst_i),
	.op_valid_i(op_valid_i),
	.op_sel_i(op_sel_i),
	.op_ready_o(op_ready_o),
	.pc_load_o(pc_load_o),
	.flush_o(flush_o),
	.global_irq_enable_o(global_irq_enable_o),
	.stack_ptr_o(stack_ptr_o),
	.done_o(done_o)
);

// ===== sim/bre_exec_tb.sv
`timescale 1ns/10ps
module bre_exec_tb;
	reg ref_clk_i = 0, sys_rst_i = 1, op_valid_i = 0, dest_file_i = 0;
	reg push_i = 0, fl, done_seen;
	reg [2:0] op_sel_i = 0, bit_idx_i = 0;
	reg [6:0] file_addr_i = 0;
	reg [7:0] imm_i = 0;
	reg [12:0] push_pc_i = 0;
	wire op_ready_o, zero_flag_o, pc_load_o, flush_o, global_irq_enable_o;
	wire done_o;
	wire [7:0] acc_o, interrupt_control_reg_o;
	wire [12:0] pc_o;
	wire [2:0] stack_ptr_o;
	integer n_errors = 0, n_compared = 0, i, n;
	bre_exec u_bre_exec (
		.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i),
		.op_valid_i(op_valid_i),
		.op_sel_i(op_sel_i),
		.file_addr_i(file_addr_i),
		.bit_idx_i(bit_idx_i),
		.dest_file_i(dest_file_i),
		.imm_i(imm_i),
		.push_i(push_i),
		.push_pc_i(push_pc_i),
		.op_ready_o(op_ready_o),
		.acc_o(acc_o),
		.zero_flag_o(zero_flag_o),
		.pc_o(pc_o),
		.pc_load_o(pc_load_o),
		.flush_o(flush_o),
		.interrupt_control_reg_o(interrupt_control_reg_o),
		.global_irq_enable_o(global_irq_enable_o),
		.stack_ptr_o(stack_ptr_o),
		.done_o(done_o)
	);
	initial forever #5 ref_clk_i = ~ref_clk_i;
	task complete_run; begin
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	end endtask
	task chk(input [12:0] g, input [12:0] e); begin
		n_compared = n_compared + 1;
		if (g !== e) begin
			n_errors = n_errors + 1;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	end endtask
	task op(input [2:0] s, input [6:0] a, input [2:0] b, input d,
		input [7:0] k, input [12:0] lat); begin
		@(posedge ref_clk_i);
		op_valid_i <= 1'h1;
		{op_sel_i, file_addr_i, bit_idx_i} <= {s, a, b};
		{dest_file_i, imm_i} <= {d, k};
		@(negedge ref_clk_i);
		chk(op_ready_o, 1);
		@(posedge ref_clk_i);
		op_valid_i <= 1'h0;
		n = 0;
		fl = 0;
		done_seen = 0;
		while (!done_seen) begin
			@(negedge ref_clk_i);
			n = n + 1;
			fl = fl | flush_o;
			done_seen = (done_o === 1'h1);
			if (n > 5) begin
				n_errors = n_errors + 1;
				complete_run;
			end
		end
		chk(n[12:0], lat);
		chk(fl, lat == 3 && s == 3'h4);
		chk(pc_load_o, s > 3'h4);
	end endtask
	task s_ret; begin
		for (i = 0; i < 3; i = i + 1) begin
			@(posedge ref_clk_i);
			push_i <= 1'h1;
			push_pc_i <= 13'h1ff0 + i[12:0];
			@(posedge ref_clk_i);
			push_i <= 1'h0;
		end
		chk(global_irq_enable_o, 0);
		op(5, 0, 0, 0, 0, 3);
		chk(pc_o, 13'h1ff2);
		chk(interrupt_control_reg_o, 8'h80);
		chk(global_irq_enable_o, 1);
		op(6, 0, 0, 0, 8'hff, 3);
		chk(pc_o, 13'h1ff1);
		chk(acc_o, 8'hff);
		op(7, 0, 0, 0, 0, 3);
		chk(pc_o, 13'h1ff0);
		chk(stack_ptr_o, 0);
	end endtask
	task s_and; begin
		for (i = 0; i < 8; i = i + 1) op(1, 7'h7f, i[2:0], 0, 0, 2);
		op(2, 0, 0, 0, 8'h5a, 1);
		chk(acc_o, 8'h5a);
		chk(zero_flag_o, 0);
		op(3, 7'h7f, 0, 1, 0, 2);
		op(3, 7'h7f, 0, 0, 0, 2);
		chk(zero_flag_o, 0);
		chk(acc_o, 8'h5a);
		op(4, 7'h7f, 0, 0, 0, 3);
		op(4, 7'h7f, 1, 0, 0, 2);
		op(2, 0, 0, 0, 8'h00, 1);
		chk(zero_flag_o, 1);
		op(1, 7'h00, 7, 0, 0, 2);
		chk(zero_flag_o, 1);
		op(4, 7'h00, 7, 0, 0, 2);
		chk(zero_flag_o, 1);
	end endtask
	initial begin
		repeat (20) @(posedge ref_clk_i);
		sys_rst_i <= 1'h0;
		s_ret;
		s_and;
		complete_run;
	end
endmodule // bre_exec_tb
